// File: design/pbcs_regs.sv
// Purpose: basic control and upper basic status registers of a 10/100 PHY
// Assumes: management frames decoded elsewhere into one-cycle read/write strobes
// Notes:   soft reset reloads control bits and re-latches the strap
`timescale 1ns/10ps
`include "pbcs_defines.svh"

// Operation
// R1: writing one to bit 15 soft-resets device; bit self-clears, reads zero.
// R2: bit 14 selects loopback; resets to zero.
// R3: bit 13 picks 100/10 Mbps; ignored under auto-negotiation; reset from strap.
// R4: bit 12 enables auto-negotiation; negotiated result overrides speed and duplex; strap reset.
// R5: bit 11 selects power-down; resets to zero.
// R6: leaving power-down via reset bit takes two writes: first clears, second resets.
// R7: bit 10 isolates the MAC-side interface; resets to zero.
// R8: bit 9 restarts negotiation and self-clears; bit 8 selects full duplex, resets one.
// R9: status bits 15..12 are fixed capability flags: 0,1,1,1.
// R10: bit 7 enables collision test; bits 6..0 read zero, writes ignored.
// R11: 16-bit registers reached by number; writes to read-only bits ignored.
module pbcs_regs (
   // clock and reset
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_rstn,
   // strap pin
   input  wire logic                 i_negotiation_speed_strap,
   // management access
   input  wire logic                 i_wr,
   input  wire logic                 i_rd,
   input  wire pbcs_pkg::pbcs_regnum_t i_regnum,
   input  wire pbcs_pkg::pbcs_word_t   i_wdata,
   output pbcs_pkg::pbcs_word_t        o_rdata,
   output logic                        o_rvalid,
   // negotiation results
   input  wire logic                 i_aneg_speed_100,
   input  wire logic                 i_aneg_full_duplex,
   // controls to the device
   output logic                      o_soft_reset,
   output logic                      o_loopback,
   output logic                      o_power_down,
   output logic                      o_isolate,
   output logic                      o_aneg_enable,
   output logic                      o_aneg_restart,
   output logic                      o_col_test,
   output logic                      o_speed_100,
   output logic                      o_full_duplex
);
   import pbcs_pkg::*;

   logic        strap_sync;
   logic        loop_reg,   loop_next;
   logic        speed_reg,  speed_next;
   logic        aneg_reg,   aneg_next;
   logic        pwrdn_reg,  pwrdn_next;
   logic        iso_reg,    iso_next;
   logic        duplex_reg, duplex_next;
   logic        col_reg,    col_next;
   logic        restart_reg, restart_next;
   logic        srst_reg,   srst_next;
   logic [3:0]  cnt_reg,    cnt_next;
   pbcs_state_e state_reg,  state_next;
   pbcs_word_t  rdata_reg,  rdata_next;
   logic        rvalid_reg, rvalid_next;
   logic        spd_out_reg, spd_out_next;
   logic        dup_out_reg, dup_out_next;
   logic        wr_ctrl;
   pbcs_word_t  ctrl_view;

   // strap is read only in the latch state, after reset or soft reset
   pbcs_strap_sync u_strap (
      .i_ref_clk (i_ref_clk),
      .i_pin     (i_negotiation_speed_strap),
      .o_sync    (strap_sync)
   );

   // writes in soft reset or the latch cycle are dropped silently
   // R11: register number decode
   assign wr_ctrl = i_wr && (i_regnum == `PBCS_REG_CTRL) && (state_reg == PBCS_RUN);

   // R1 R10: reset bit reads zero, bits 6..0 read zero
   always_comb begin
      ctrl_view = 16'h0000;
      ctrl_view[`PBCS_BIT_LOOPBACK] = loop_reg;
      ctrl_view[`PBCS_BIT_SPEED]    = speed_reg;
      ctrl_view[`PBCS_BIT_ANEG_EN]  = aneg_reg;
      ctrl_view[`PBCS_BIT_PWRDN]    = pwrdn_reg;
      ctrl_view[`PBCS_BIT_ISOLATE]  = iso_reg;
      ctrl_view[`PBCS_BIT_ANEG_RST] = restart_reg;
      ctrl_view[`PBCS_BIT_DUPLEX]   = duplex_reg;
      ctrl_view[`PBCS_BIT_COL_TEST] = col_reg;
   end

   always_comb begin
      loop_next    = loop_reg;
      speed_next   = speed_reg;
      aneg_next    = aneg_reg;
      pwrdn_next   = pwrdn_reg;
      iso_next     = iso_reg;
      duplex_next  = duplex_reg;
      col_next     = col_reg;
      restart_next = 1'b0;
      srst_next    = 1'b0;
      cnt_next     = cnt_reg;
      state_next   = state_reg;
      case (state_reg)
         PBCS_RUN: begin
            if (wr_ctrl) begin
               // R6: first reset write while powered down only wakes
               if (i_wdata[`PBCS_BIT_RESET] && pwrdn_reg) begin
                  pwrdn_next = 1'b0;
               // R1: soft reset, bit never stored
               end else if (i_wdata[`PBCS_BIT_RESET]) begin
                  state_next = PBCS_SOFT;
                  cnt_next   = `PBCS_RST_PULSE_CYC;
                  srst_next  = 1'b1;
               end else begin
                  // R2 R3 R4 R5 R7 R8 R10: writable bits
                  loop_next    = i_wdata[`PBCS_BIT_LOOPBACK];
                  speed_next   = i_wdata[`PBCS_BIT_SPEED];
                  aneg_next    = i_wdata[`PBCS_BIT_ANEG_EN];
                  pwrdn_next   = i_wdata[`PBCS_BIT_PWRDN];
                  iso_next     = i_wdata[`PBCS_BIT_ISOLATE];
                  duplex_next  = i_wdata[`PBCS_BIT_DUPLEX];
                  col_next     = i_wdata[`PBCS_BIT_COL_TEST];
                  // R8: restart pulse, self-clearing
                  restart_next = i_wdata[`PBCS_BIT_ANEG_RST];
               end
            end
         end
         PBCS_SOFT: begin
            // hold soft reset a few cycles so slow logic sees it
            srst_next = 1'b1;
            cnt_next  = cnt_reg - 4'h1;
            if (cnt_reg == 4'h1) begin
               state_next = PBCS_LATCH;
            end
         end
         PBCS_LATCH: begin
            // R3 R4: re-latch strap, reload defaults
            loop_next   = 1'b0;
            pwrdn_next  = 1'b0;
            iso_next    = 1'b0;
            col_next    = 1'b0;
            duplex_next = `PBCS_DUPLEX_RST;
            speed_next  = strap_sync;
            aneg_next   = strap_sync;
            state_next  = PBCS_RUN;
         end
         default: begin
            state_next = PBCS_RUN;
         end
      endcase
   end

   // one cycle lag keeps these outputs straight from flops
   // R4 R3: negotiated result overrides manual speed and duplex
   always_comb begin
      spd_out_next = aneg_reg ? i_aneg_speed_100 : speed_reg;
      dup_out_next = aneg_reg ? i_aneg_full_duplex : duplex_reg;
   end

   // read data holds until the next read
   // R9 R11: read mux, unmapped numbers read zero
   always_comb begin
      rvalid_next = i_rd;
      rdata_next  = rdata_reg;
      if (i_rd) begin
         case (i_regnum)
            `PBCS_REG_CTRL: rdata_next = ctrl_view;
            `PBCS_REG_STAT: rdata_next = `PBCS_STAT_CAPS;
            default:        rdata_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         state_reg   <= PBCS_LATCH;
         loop_reg    <= 1'b0;
         speed_reg   <= 1'b0;
         aneg_reg    <= 1'b0;
         pwrdn_reg   <= 1'b0;
         iso_reg     <= 1'b0;
         duplex_reg  <= `PBCS_DUPLEX_RST;
         col_reg     <= 1'b0;
         restart_reg <= 1'b0;
         srst_reg    <= 1'b0;
         cnt_reg     <= 4'h0;
         rdata_reg   <= 16'h0000;
         rvalid_reg  <= 1'b0;
         spd_out_reg <= 1'b0;
         dup_out_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         loop_reg    <= loop_next;
         speed_reg   <= speed_next;
         aneg_reg    <= aneg_next;
         pwrdn_reg   <= pwrdn_next;
         iso_reg     <= iso_next;
         duplex_reg  <= duplex_next;
         col_reg     <= col_next;
         restart_reg <= restart_next;
         srst_reg    <= srst_next;
         cnt_reg     <= cnt_next;
         rdata_reg   <= rdata_next;
         rvalid_reg  <= rvalid_next;
         spd_out_reg <= spd_out_next;
         dup_out_reg <= dup_out_next;
      end
   end

   assign o_rdata        = rdata_reg;
   assign o_rvalid       = rvalid_reg;
   assign o_soft_reset   = srst_reg;
   assign o_loopback     = loop_reg;
   assign o_power_down   = pwrdn_reg;
   assign o_isolate      = iso_reg;
   assign o_aneg_enable  = aneg_reg;
   assign o_aneg_restart = restart_reg;
   assign o_col_test     = col_reg;
   assign o_speed_100    = spd_out_reg;
   assign o_full_duplex  = dup_out_reg;
endmodule

// File: design/pbcs_defines.svh
// Purpose: constants for the basic control/status register bank
// Assumes: 16-bit registers reached by register number
// Notes:   none
`ifndef PBCS_DEFINES_SVH
`define PBCS_DEFINES_SVH
`define PBCS_REG_CTRL      5'h00
`define PBCS_REG_STAT      5'h01
`define PBCS_BIT_RESET     15
`define PBCS_BIT_LOOPBACK  14
`define PBCS_BIT_SPEED     13
`define PBCS_BIT_ANEG_EN   12
`define PBCS_BIT_PWRDN     11
`define PBCS_BIT_ISOLATE   10
`define PBCS_BIT_ANEG_RST  9
`define PBCS_BIT_DUPLEX    8
`define PBCS_BIT_COL_TEST  7
`define PBCS_DUPLEX_RST    1'b1
`define PBCS_STAT_CAPS     16'h7000
`define PBCS_RST_PULSE_CYC 4'h4
`endif

// File: design/pbcs_pkg.sv
// Purpose: types for the basic control/status register bank
// Assumes: none
// Notes:   none
package pbcs_pkg;
   typedef logic [15:0] pbcs_word_t;
   typedef logic [4:0]  pbcs_regnum_t;
   typedef enum logic [2:0] {
      PBCS_RUN   = 3'b001,
      PBCS_SOFT  = 3'b010,
      PBCS_LATCH = 3'b100
   } pbcs_state_e;
endpackage

// File: design/pbcs_strap_sync.sv
// Purpose: two-flop synchroniser for the strap pin
// Assumes: pin is asynchronous to i_ref_clk
// Notes:   runs through reset so the strap is settled at release
`timescale 1ns/10ps
module pbcs_strap_sync (
   // clock
   input  wire logic i_ref_clk,
   // pin in, synchronised out
   input  wire logic i_pin,
   output logic      o_sync
);
   logic meta_reg;
   logic sync_reg;
   // no reset: a reset value here would be latched as the strap at release
   always_ff @(posedge i_ref_clk) begin
      meta_reg <= i_pin;
      sync_reg <= meta_reg;
   end
   assign o_sync = sync_reg;
endmodule

// File: verification/pbcs_regs_monitor.sv
// Purpose: checker for the control/status bank
// Assumes: one clock, sync reset
// Notes:   bound to pbcs_regs
`timescale 1ns/10ps
module pbcs_regs_monitor (
   // clock and reset
   input wire logic                   i_ref_clk,
   input wire logic                   i_rstn,
   // management access
   input wire logic                   i_wr,
   input wire logic                   i_rd,
   input wire pbcs_pkg::pbcs_regnum_t i_regnum,
   input wire pbcs_pkg::pbcs_word_t   i_wdata,
   input wire pbcs_pkg::pbcs_word_t   o_rdata,
   input wire logic                   o_rvalid,
   // negotiation results
   input wire logic                   i_aneg_speed_100,
   input wire logic                   i_aneg_full_duplex,
   // controls to the device
   input wire logic                   o_soft_reset,
   input wire logic                   o_loopback,
   input wire logic                   o_power_down,
   input wire logic                   o_isolate,
   input wire logic                   o_aneg_enable,
   input wire logic                   o_aneg_restart,
   input wire logic                   o_col_test,
   input wire logic                   o_speed_100,
   input wire logic                   o_full_duplex
);
   import pbcs_pkg::*;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   // control write outside soft reset (which spans its latch cycle) and outside the first cycle after it
   sequence ctrl_wr;
      i_wr && i_regnum == 5'h00 && !o_soft_reset && !$past(o_soft_reset);
   endsequence
   chk_read_answer: assert property (o_rvalid == $past(i_rd))
      else $error("read answer wrong");
   chk_status_caps: assert property (i_rd && i_regnum == 5'h01 |=> o_rdata == 16'h7000)
      else $error("status caps wrong");
   chk_rdata_hold: assert property (!i_rd |=> $stable(o_rdata))
      else $error("read data moved");
   chk_soft_width: assert property ($rose(o_soft_reset) |-> o_soft_reset [*5] ##1 !o_soft_reset)
      else $error("soft reset width");
   chk_restart_pulse: assert property (ctrl_wr ##0 !i_wdata[15] ##1 !i_wr |->
      o_aneg_restart == $past(i_wdata[9]) ##1 !o_aneg_restart) else $error("restart pulse");
   chk_ctrl_levels: assert property (ctrl_wr ##0 !i_wdata[15] |=> o_loopback == $past(i_wdata[14])
      && o_power_down == $past(i_wdata[11]) && o_isolate == $past(i_wdata[10])
      && o_col_test == $past(i_wdata[7]) && o_aneg_enable == $past(i_wdata[12])) else $error("ctrl levels");
   chk_pd_exit: assert property (ctrl_wr ##0 i_wdata[15] && o_power_down |=> !o_power_down && !o_soft_reset)
      else $error("power-down exit");
   chk_aneg_wins: assert property (o_aneg_enable |=> o_speed_100 == $past(i_aneg_speed_100)
      && o_full_duplex == $past(i_aneg_full_duplex)) else $error("negotiated mode");
   chk_manual_speed: assert property (ctrl_wr ##0 !i_wdata[15] && !i_wdata[12] |=> ##1
      o_speed_100 == $past(i_wdata[13], 2) && o_full_duplex == $past(i_wdata[8], 2)) else $error("manual mode");
   chk_status_ro: assert property (i_wr && i_regnum != 5'h00 && !o_soft_reset |=>
      $stable(o_loopback) && $stable(o_isolate)) else $error("status write took");
   cover property ($rose(o_soft_reset));
   cover property (ctrl_wr ##0 i_wdata[15] && o_power_down);
   cover property (o_aneg_restart);
endmodule
bind pbcs_regs pbcs_regs_monitor i_pbcs_regs_monitor (
   .i_ref_clk          (i_ref_clk),
   .i_rstn             (i_rstn),
   .i_wr               (i_wr),
   .i_rd               (i_rd),
   .i_regnum           (i_regnum),
   .i_wdata            (i_wdata),
   .o_rdata            (o_rdata),
   .o_rvalid           (o_rvalid),
   .i_aneg_speed_100   (i_aneg_speed_100),
   .i_aneg_full_duplex (i_aneg_full_duplex),
   .o_soft_reset       (o_soft_reset),
   .o_loopback         (o_loopback),
   .o_power_down       (o_power_down),
   .o_isolate          (o_isolate),
   .o_aneg_enable      (o_aneg_enable),
   .o_aneg_restart     (o_aneg_restart),
   .o_col_test         (o_col_test),
   .o_speed_100        (o_speed_100),
   .o_full_duplex      (o_full_duplex)
);

// File: verification/pbcs_mgmt_model.sv
// Purpose: management controller issuing read/write frames
// Assumes: one strobe cycle per frame
// Notes:   idle data is scrambled after a write, idle address after a read
`timescale 1ns/10ps
module pbcs_mgmt_model (
   input  wire logic             i_ref_clk,
   output logic                  o_wr = 1'b0,
   output logic                  o_rd = 1'b0,
   output pbcs_pkg::pbcs_regnum_t o_regnum = 5'h00,
   output pbcs_pkg::pbcs_word_t   o_wdata = 16'h0000
);
   import pbcs_pkg::*;
   task automatic write_word(input pbcs_regnum_t r, input pbcs_word_t d);
      @(posedge i_ref_clk);
      o_wr <= 1'b1;
      o_regnum <= r;
      o_wdata <= d;
      @(posedge i_ref_clk);
      o_wr <= 1'b0;
      o_wdata <= ~d;
   endtask
   task automatic read_frame(input pbcs_regnum_t r);
      @(posedge i_ref_clk);
      o_rd <= 1'b1;
      o_regnum <= r;
      @(posedge i_ref_clk);
      o_rd <= 1'b0;
      o_regnum <= ~r;
   endtask
endmodule

// File: verification/phy_basic_control_status_regs_tb.sv
// Purpose: self-checking bench for the control/status bank
// Assumes: strap high at power-up
// Notes:   one task per scenario
`timescale 1ns/10ps
module phy_basic_control_status_regs_tb;
   import pbcs_pkg::*;
   logic         i_ref_clk = 1'b0;
   logic         i_rstn = 1'b0;
   logic         i_negotiation_speed_strap = 1'b1;
   logic         i_aneg_speed_100 = 1'b0;
   logic         i_aneg_full_duplex = 1'b1;
   logic         i_wr, i_rd, o_rvalid, o_soft_reset, o_loopback, o_power_down, o_isolate;
   logic         o_aneg_enable, o_aneg_restart, o_col_test, o_speed_100, o_full_duplex;
   pbcs_regnum_t i_regnum;
   pbcs_word_t   i_wdata, o_rdata;
   int           miscompares = 0;
   int           check_count = 0;
   int           cycles = 0;
   always #50 i_ref_clk = ~i_ref_clk;
   pbcs_regs i_pbcs_regs (
      .i_ref_clk                 (i_ref_clk),
      .i_rstn                    (i_rstn),
      .i_negotiation_speed_strap (i_negotiation_speed_strap),
      .i_wr                      (i_wr),
      .i_rd                      (i_rd),
      .i_regnum                  (i_regnum),
      .i_wdata                   (i_wdata),
      .o_rdata                   (o_rdata),
      .o_rvalid                  (o_rvalid),
      .i_aneg_speed_100          (i_aneg_speed_100),
      .i_aneg_full_duplex        (i_aneg_full_duplex),
      .o_soft_reset              (o_soft_reset),
      .o_loopback                (o_loopback),
      .o_power_down              (o_power_down),
      .o_isolate                 (o_isolate),
      .o_aneg_enable             (o_aneg_enable),
      .o_aneg_restart            (o_aneg_restart),
      .o_col_test                (o_col_test),
      .o_speed_100               (o_speed_100),
      .o_full_duplex             (o_full_duplex)
   );
   pbcs_mgmt_model i_pbcs_mgmt_model (.i_ref_clk, .o_wr(i_wr), .o_rd(i_rd), .o_regnum(i_regnum), .o_wdata(i_wdata));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input pbcs_regnum_t r, input pbcs_word_t d);
      i_pbcs_mgmt_model.write_word(r, d);
      #1;
   endtask
   task automatic rd(input pbcs_regnum_t r, input pbcs_word_t exp, input string what);
      i_pbcs_mgmt_model.read_frame(r);
      #1;
      check("rvalid", o_rvalid, 16'h0001);
      check(what, o_rdata, exp);
   endtask
   task automatic t_reset_vals();
      rd(5'h00, 16'h3100, "ctrl reset");
      rd(5'h01, 16'h7000, "status");
      wr(5'h01, 16'h8FFF);
      rd(5'h01, 16'h7000, "status ro");
      rd(5'h1F, 16'h0000, "unmapped");
      check("speed aneg", o_speed_100, 16'h0000);
      check("aneg strap", o_aneg_enable, 16'h0001);
   endtask
   task automatic t_ctrl_levels();
      wr(5'h00, 16'h4C8F);
      check("loopback", o_loopback, 16'h0001);
      check("pwrdn", o_power_down, 16'h0001);
      check("isolate", o_isolate, 16'h0001);
      check("coltest", o_col_test, 16'h0001);
      rd(5'h00, 16'h4C80, "ctrl rb");
      check("duplex", o_full_duplex, 16'h0000);
      wr(5'h00, 16'h2100);
      @(posedge i_ref_clk);
      #1;
      check("speed", o_speed_100, 16'h0001);
      check("pwrdn off", o_power_down, 16'h0000);
   endtask
   task automatic t_restart();
      wr(5'h00, 16'h1200);
      check("restart", o_aneg_restart, 16'h0001);
      check("aneg on", o_aneg_enable, 16'h0001);
      @(posedge i_ref_clk);
      i_aneg_speed_100 <= 1'b1;
      #1;
      check("restart clr", o_aneg_restart, 16'h0000);
      rd(5'h00, 16'h1000, "restart rb");
      check("speed neg", o_speed_100, 16'h0001);
   endtask
   task automatic t_soft_reset();
      wr(5'h00, 16'h0800);
      wr(5'h00, 16'h8000);
      check("pd exit", o_power_down, 16'h0000);
      check("no reset", o_soft_reset, 16'h0000);
      @(posedge i_ref_clk);
      i_negotiation_speed_strap <= 1'b0;
      wr(5'h00, 16'h8000);
      check("soft reset", o_soft_reset, 16'h0001);
      repeat (8) @(posedge i_ref_clk);
      rd(5'h00, 16'h0100, "relatched");
   endtask
   task automatic report_and_stop();
      if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      t_reset_vals();
      t_ctrl_levels();
      t_restart();
      t_soft_reset();
      report_and_stop();
   end
   // hang guard well above the run length
   always @(posedge i_ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         miscompares++;
         report_and_stop();
      end
   end
endmodule
